// ==== core/rct_div_if.sv ====
// divider request and answer between estimator and divider
`timescale 1ns/1ps
interface rct_div_if;
  logic        start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        busy;
  logic        done;
  logic [31:0] quotient;
  modport master (output start, dividend, divisor, input busy, done, quotient);
  modport slave  (input start, dividend, divisor, output busy, done, quotient);
endinterface

// ==== core/rct_divider.sv ====
// sequential 32-bit restoring divider, divide by zero gives all ones
`timescale 1ns/1ps
module rct_divider
  import rct_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  rct_div_if.slave  div
);
  logic [31:0] rem_q, rem_d;
  logic [31:0] quo_q, quo_d;
  logic [31:0] den_q, den_d;
  logic [5:0]  cnt_q, cnt_d;
  logic        busy_q, busy_d;
  logic        done_q, done_d;
  logic [32:0] shifted;
  logic [32:0] trial;

  assign shifted = {rem_q, quo_q[31]};
  assign trial   = shifted - {1'b0, den_q};

  always_comb begin
    rem_d  = rem_q;
    quo_d  = quo_q;
    den_d  = den_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (div.start && !busy_q) begin
      rem_d  = '0;
      quo_d  = div.dividend;
      den_d  = div.divisor;
      cnt_d  = DIV_STEPS;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (!trial[32]) begin
        rem_d = trial[31:0];
        quo_d = {quo_q[30:0], 1'b1};
      end else begin
        rem_d = shifted[31:0];
        quo_d = {quo_q[30:0], 1'b0};
      end
      cnt_d = cnt_q - 6'h01;
      if (cnt_q == 6'h01) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rem_q  <= '0;
      quo_q  <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      den_q  <= den_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign div.busy     = busy_q;
  assign div.done     = done_q;
  assign div.quotient = quo_q;
endmodule

// ==== core/rct_pkg.sv ====
// constants, types and helpers shared by the ripple counter tuning block
package rct_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  // register byte offsets
  localparam logic [7:0] OFS_TUNE  = 8'h00;
  localparam logic [7:0] OFS_MOTOR = 8'h04;
  localparam logic [7:0] OFS_SPEED = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  // tune register field positions
  localparam int F_GAIN  = 0;
  localparam int F_QF    = 2;
  localparam int F_MECH  = 6;
  localparam int F_VSNS  = 9;
  localparam int F_OCUT  = 10;
  localparam int F_BLANK = 12;
  localparam int F_MISS  = 14;
  localparam int F_WSCL  = 16;
  localparam int TUNE_W  = 18;
  // motor register field positions
  localparam int F_KMC   = 0;
  localparam int F_KSCL  = 8;
  localparam int MOTOR_W = 10;
  // reset values
  localparam logic [1:0] GAIN_RST  = 2'h3;
  localparam logic [3:0] QF_RST    = 4'h6;
  localparam logic [2:0] MECH_RST  = 3'h4;
  localparam logic       VSNS_RST  = 1'b0;
  localparam logic [1:0] OCUT_RST  = 2'h0;
  localparam logic [1:0] BLANK_RST = 2'h0;
  localparam logic [1:0] MISS_RST  = 2'h0;
  localparam logic [1:0] WSCL_RST  = 2'h0;
  localparam logic [7:0] KMC_RST   = 8'hA3;
  localparam logic [1:0] KSCL_RST  = 2'h3;
  localparam logic [TUNE_W-1:0]  TUNE_RST  = {WSCL_RST, MISS_RST, BLANK_RST, OCUT_RST,
                                              VSNS_RST, MECH_RST, QF_RST, GAIN_RST};
  localparam logic [MOTOR_W-1:0] MOTOR_RST = {KSCL_RST, KMC_RST};
  // estimator constants
  localparam logic [4:0]  KMC_SHIFT   = 5'h17;
  localparam logic [7:0]  KSCALE_MULT = 8'h18;
  localparam logic [31:0] SPEED_K     = 32'h077D79DA; // 2*pi*CLK_HZ, rad/s per cycle
  localparam logic [4:0]  WSCL_BASE   = 5'h04;        // 16 rad/s per count
  localparam logic [4:0]  MECH_BASE   = 5'h02;
  localparam logic [4:0]  OCUT_BASE   = 5'h03;
  localparam logic [4:0]  CENTER_OFS  = 5'h03;
  localparam logic [5:0]  DIV_STEPS   = 6'h20;
  localparam logic signed [15:0] DET_HYST = 16'sh0010;
  localparam logic [23:0] INTERVAL_MAX = 24'hFFFFFF;
  localparam logic [7:0]  SPEED_MAX    = 8'hFF;
  // ripple pulse width
  localparam int unsigned PULSE_NS  = 10_000;
  localparam int unsigned PULSE_CYC = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0]  PULSE_LEN = 8'(PULSE_CYC);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_INTV = 3'b010,
    ST_SPD  = 3'b100
  } rct_state_e;

  // quality factor in 1/256 units
  function automatic logic [8:0] rct_qf_q8(input logic [3:0] code);
    unique case (code)
      4'h0:    return 9'h002;
      4'h1:    return 9'h004;
      4'h2:    return 9'h008;
      4'h3:    return 9'h010;
      4'h4:    return 9'h020;
      4'h5:    return 9'h040;
      4'h6:    return 9'h080;
      4'h7:    return 9'h0A0;
      4'h8:    return 9'h0C0;
      4'h9:    return 9'h0D3;
      default: return 9'h100;
    endcase
  endfunction

  // window percentage in 1/1024 units: 20, 30, 40, 50 %
  function automatic logic [9:0] rct_pct_q10(input logic [1:0] code);
    unique case (code)
      2'h0: return 10'h0CD;
      2'h1: return 10'h133;
      2'h2: return 10'h19A;
      2'h3: return 10'h200;
    endcase
  endfunction

  // motor constant scale 24*2^8, 2^9, 2^12, 2^13 relative to 24*2^8
  function automatic logic [2:0] rct_kscl_sh(input logic [1:0] code);
    unique case (code)
      2'h0: return 3'h0;
      2'h1: return 3'h1;
      2'h2: return 3'h4;
      2'h3: return 3'h5;
    endcase
  endfunction

  // index of highest set bit
  function automatic logic [4:0] rct_msb(input logic [23:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction
endpackage

// ==== core/rct_ripple_tuning.sv ====
// ripple counter with tunable band-pass, error corrector and speed readout
// Overview of operation
// RULE1 - detected ripple amplitude is multiplied by the selected band-pass gain
// RULE2 - quality factor code 0 to 9 steps up, codes 10 to 15 give one
// RULE3 - quality factor field resets to code 6, a factor of one half
// RULE4 - band-pass centre tracks the estimated ripple frequency
// RULE5 - counter output low-pass; larger code gives slower response
// RULE6 - mechanical response filter field resets to code 4
// RULE7 - sense method 0 filters the output pin difference for motor voltage
// RULE8 - sense method 1 takes duty cycle times supply voltage
// RULE9 - analog sensing uses the output analog cut-off setting
// RULE10 - ripples inside the blanking window after a count are dropped
// RULE11 - blanking window is 20, 30, 40 or 50 percent of interval
// RULE12 - no ripple within the expected window adds one ripple
// RULE13 - missed window is 20, 30, 40 or 50 percent of interval
// RULE14 - speed register counts units of 16, 32, 64 or 128 rad/s
// RULE15 - pulse output shows one pulse per counted ripple; the code merges counts PULSE_LEN or fewer cycles apart into one pulse
// RULE16 - speed rises with motor constant scale, falls with constant value
// RULE17 - motor constant resets to 163, its scale to code 3
// RULE18 - fields hold until rewritten; new values apply at next evaluation
// RULE19 - mechanical filter cut-off scales monotonically with its code
`timescale 1ns/1ps
module rct_ripple_tuning
  import rct_pkg::*;
(
  input  wire logic               REF_CLK_IN,
  input  wire logic               RST_IN,
  input  wire logic               PSEL_IN,
  input  wire logic               PENABLE_IN,
  input  wire logic               PWRITE_IN,
  input  wire logic [7:0]         PADDR_IN,
  input  wire logic [31:0]        PWDATA_IN,
  output logic      [31:0]        PRDATA_OUT,
  output logic                    PREADY_OUT,
  output logic                    PSLVERR_OUT,
  input  wire logic signed [11:0] MOTOR_CURRENT_IN,
  input  wire logic [7:0]         OUTPUT_DIFF_IN,
  input  wire logic [7:0]         PWM_DUTY_IN,
  input  wire logic [7:0]         MOTOR_SUPPLY_VOLTAGE_IN,
  output logic                    RIPPLE_PULSE_OUTPUT_OUT,
  output logic [1:0]              OUTPUT_ANALOG_CUTOFF_OUT,
  output logic [7:0]              MOTOR_VOLTAGE_OUT
);
  rct_div_if div_if ();

  rct_divider u_div (
    .clk_in (REF_CLK_IN),
    .rst_in (RST_IN),
    .div    (div_if.slave)
  );

  // register bus
  logic [TUNE_W-1:0]  tune_q, tune_d;
  logic [MOTOR_W-1:0] motor_q, motor_d;
  logic [31:0]        prdata_q, prdata_d;
  // estimator
  rct_state_e         state_q, state_d;
  logic [TUNE_W-1:0]  act_tune_q, act_tune_d;
  logic [MOTOR_W-1:0] act_motor_q, act_motor_d;
  logic [23:0]        interval_q, interval_d;
  logic [17:0]        speed_acc_q, speed_acc_d;
  // filters
  logic [15:0]        v_acc_q, v_acc_d;
  logic [7:0]         volt_q, volt_d;
  logic signed [35:0] lo_acc_q, lo_acc_d;
  logic signed [35:0] hi_acc_q, hi_acc_d;
  logic               armed_q, armed_d;
  // corrector
  logic [23:0]        since_q, since_d;
  logic [15:0]        count_q, count_d;
  logic [7:0]         pulse_q, pulse_d;

  logic               bus_setup;
  logic               bus_write;
  logic               addr_hit;
  logic               detect;
  logic               cnt_ev;
  logic signed [15:0] band;

  function automatic logic signed [35:0] lp_step(input logic signed [35:0] acc,
                                                 input logic signed [15:0] x,
                                                 input logic [4:0]         sh);
    logic signed [35:0] diff;
    diff = (36'(x) <<< 16) - acc;
    return acc + (diff >>> sh);
  endfunction

  function automatic logic [23:0] window_of(input logic [23:0] ivl,
                                            input logic [1:0]  code,
                                            input logic        half);
    logic [33:0] prod;
    prod = 34'(ivl) * 34'(rct_pct_q10(code));
    return half ? 24'(prod[33:11]) : prod[33:10];
  endfunction

  assign bus_setup = PSEL_IN && !PENABLE_IN;
  assign bus_write = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign addr_hit  = (PADDR_IN == OFS_TUNE) || (PADDR_IN == OFS_MOTOR) ||
                     (PADDR_IN == OFS_SPEED) || (PADDR_IN == OFS_COUNT);

  // ---------------- register bus ----------------
  always_comb begin
    tune_d   = tune_q;
    motor_d  = motor_q;
    prdata_d = prdata_q;
    if (bus_setup) begin
      unique case (PADDR_IN)
        OFS_TUNE:  prdata_d = 32'(tune_q);
        OFS_MOTOR: prdata_d = 32'(motor_q);
        OFS_SPEED: prdata_d = 32'(speed_acc_q[15:8]);
        OFS_COUNT: prdata_d = 32'(count_q);
        default:   prdata_d = '0;
      endcase
    end
    if (bus_write && PADDR_IN == OFS_TUNE) begin
      tune_d = PWDATA_IN[TUNE_W-1:0]; // [RULE18]
    end
    if (bus_write && PADDR_IN == OFS_MOTOR) begin
      motor_d = PWDATA_IN[MOTOR_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      tune_q   <= TUNE_RST; // [RULE3] [RULE6]
      motor_q  <= MOTOR_RST; // [RULE17]
      prdata_q <= '0;
    end else begin
      tune_q   <= tune_d;
      motor_q  <= motor_d;
      prdata_q <= prdata_d;
    end
  end

  assign PRDATA_OUT  = prdata_q;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_hit;

  // ---------------- estimator ----------------
  always_comb begin
    state_d         = state_q;
    act_tune_d      = act_tune_q;
    act_motor_d     = act_motor_q;
    interval_d      = interval_q;
    speed_acc_d     = speed_acc_q;
    div_if.start    = 1'b0;
    div_if.dividend = '0;
    div_if.divisor  = '0;
    unique case (state_q)
      ST_IDLE: begin
        // passes run back to back so new settings never wait on a ripple
        if (!div_if.busy) begin
          act_tune_d      = tune_q; // [RULE18]
          act_motor_d     = motor_q;
          // interval grows with constant value, shrinks with scale
          div_if.start    = 1'b1;
          div_if.dividend = 32'(motor_q[F_KMC +: 8]) << KMC_SHIFT; // [RULE16]
          div_if.divisor  = (32'(volt_q) * 32'(KSCALE_MULT))
                            << rct_kscl_sh(motor_q[F_KSCL +: 2]);
          state_d         = ST_INTV;
        end
      end
      ST_INTV: begin
        if (div_if.done) begin
          interval_d = (div_if.quotient[31:24] != 8'h00) ? INTERVAL_MAX
                       : div_if.quotient[23:0];
          state_d    = ST_SPD;
        end
      end
      ST_SPD: begin
        if (!div_if.busy && !div_if.done) begin
          div_if.start    = 1'b1;
          div_if.dividend = SPEED_K;
          div_if.divisor  = 32'(interval_q) | 32'h1;
        end
        if (div_if.done) begin
          speed_acc_d = speed_update(div_if.quotient);
          state_d     = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // scaled speed through the mechanical response low-pass
  function automatic logic [17:0] speed_update(input logic [31:0] rad_s);
    logic [31:0]        counts;
    logic [7:0]         sat;
    logic signed [18:0] diff;
    counts = rad_s >> (WSCL_BASE + 5'(act_tune_q[F_WSCL +: 2])); // [RULE14]
    sat    = (counts > 32'(SPEED_MAX)) ? SPEED_MAX : counts[7:0];
    diff   = $signed({3'h0, sat, 8'h00}) - $signed({1'b0, speed_acc_q});
    diff   = diff >>> (MECH_BASE + 5'(act_tune_q[F_MECH +: 3])); // [RULE5] [RULE19]
    return 18'($signed({1'b0, speed_acc_q}) + diff);
  endfunction

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      state_q     <= ST_IDLE;
      act_tune_q  <= TUNE_RST;
      act_motor_q <= MOTOR_RST;
      interval_q  <= INTERVAL_MAX;
      speed_acc_q <= '0;
    end else begin
      state_q     <= state_d;
      act_tune_q  <= act_tune_d;
      act_motor_q <= act_motor_d;
      interval_q  <= interval_d;
      speed_acc_q <= speed_acc_d;
    end
  end

  // ---------------- voltage sense and band-pass ----------------
  logic [4:0]         c_sh;
  logic [4:0]         spread;
  logic [8:0]         qf;
  logic signed [15:0] gained;
  logic [15:0]        duty_v;

  always_comb begin
    qf     = rct_qf_q8(act_tune_q[F_QF +: 4]); // [RULE2]
    // higher quality factor pulls the two corners together
    spread = (qf >= 9'h080) ? 5'h01 : (qf >= 9'h020) ? 5'h02 : (qf >= 9'h008) ? 5'h03 : 5'h04;
    c_sh   = (rct_msb(interval_q) > CENTER_OFS + spread) ? rct_msb(interval_q) - CENTER_OFS
             : spread; // [RULE4]
    gained = 16'(MOTOR_CURRENT_IN) <<< act_tune_q[F_GAIN +: 2]; // [RULE1]
    duty_v = 16'(PWM_DUTY_IN) * 16'(MOTOR_SUPPLY_VOLTAGE_IN);
    v_acc_d = v_acc_q + 16'(($signed({1'b0, OUTPUT_DIFF_IN, 8'h00}) - $signed({1'b0, v_acc_q}))
              >>> (OCUT_BASE + 5'(act_tune_q[F_OCUT +: 2])));  // [RULE9]
    volt_d  = act_tune_q[F_VSNS] ? duty_v[15:8] // [RULE8]
              : v_acc_q[15:8]; // [RULE7]
    lo_acc_d = lp_step(lo_acc_q, gained, c_sh + spread);
    hi_acc_d = lp_step(hi_acc_q, gained, c_sh - spread);
    band     = 16'((hi_acc_q - lo_acc_q) >>> 16);
    detect   = armed_q && (band > DET_HYST);
    armed_d  = armed_q;
    if (band < -DET_HYST) begin
      armed_d = 1'b1;
    end else if (detect) begin
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      v_acc_q  <= '0;
      volt_q   <= '0;
      lo_acc_q <= '0;
      hi_acc_q <= '0;
      armed_q  <= 1'b0;
    end else begin
      v_acc_q  <= v_acc_d;
      volt_q   <= volt_d;
      lo_acc_q <= lo_acc_d;
      hi_acc_q <= hi_acc_d;
      armed_q  <= armed_d;
    end
  end

  assign OUTPUT_ANALOG_CUTOFF_OUT = act_tune_q[F_OCUT +: 2];
  assign MOTOR_VOLTAGE_OUT        = volt_q;

  // ---------------- error corrector and pulse output ----------------
  logic [23:0] blank_len;
  logic [23:0] miss_half;

  always_comb begin
    blank_len = window_of(interval_q, act_tune_q[F_BLANK +: 2], 1'b0); // [RULE11]
    miss_half = window_of(interval_q, act_tune_q[F_MISS +: 2], 1'b1); // [RULE13]
    since_d   = (since_q == INTERVAL_MAX) ? since_q : since_q + 24'h1;
    count_d   = count_q;
    pulse_d   = (pulse_q != 8'h00) ? pulse_q - 8'h01 : pulse_q;
    cnt_ev    = 1'b0;
    if (detect && since_q >= blank_len) begin // [RULE10]
      cnt_ev  = 1'b1;
      since_d = '0;
    end else if (!detect && {1'b0, since_q} >= {1'b0, interval_q} + {1'b0, miss_half}) begin
      cnt_ev  = 1'b1; // [RULE12]
      since_d = since_q - interval_q;
    end
    if (cnt_ev) begin
      count_d = count_q + 16'h1;
      pulse_d = PULSE_LEN; // [RULE15]
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      since_q <= '0;
      count_q <= '0;
      pulse_q <= '0;
    end else begin
      since_q <= since_d;
      count_q <= count_d;
      pulse_q <= pulse_d;
    end
  end

  assign RIPPLE_PULSE_OUTPUT_OUT = (pulse_q != 8'h00);
endmodule

// ==== tb/rct_host_model.sv ====
// host side model that counts ripple pulses and their widths
`timescale 1ns/1ps
module rct_host_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        pulse_in,
  output logic      [15:0] pulses_out,
  output logic      [15:0] min_width_out
);
  logic        last_q;
  logic [15:0] width_q;
  always @(posedge clk_in) begin
    if (rst_in) begin
      last_q <= 1'b0;
      width_q <= 16'h0000;
      pulses_out <= 16'h0000;
      min_width_out <= 16'hFFFF;
    end else begin
      last_q <= pulse_in;
      width_q <= pulse_in ? width_q + 16'h0001 : 16'h0000;
      if (pulse_in && !last_q) begin
        pulses_out <= pulses_out + 16'h0001;
      end
      if (!pulse_in && last_q && width_q < min_width_out) begin
        min_width_out <= width_q;
      end
    end
  end
endmodule

// ==== tb/rct_ripple_tuning_properties.sv ====
// port assertions for the ripple counter tuning block
`timescale 1ns/1ps
module rct_ripple_tuning_properties
  import rct_pkg::*;
(
  input wire logic               REF_CLK_IN,
  input wire logic               RST_IN,
  input wire logic               PSEL_IN,
  input wire logic               PENABLE_IN,
  input wire logic               PWRITE_IN,
  input wire logic [7:0]         PADDR_IN,
  input wire logic [31:0]        PWDATA_IN,
  input wire logic [31:0]        PRDATA_OUT,
  input wire logic               PREADY_OUT,
  input wire logic               PSLVERR_OUT,
  input wire logic signed [11:0] MOTOR_CURRENT_IN,
  input wire logic [7:0]         OUTPUT_DIFF_IN,
  input wire logic [7:0]         PWM_DUTY_IN,
  input wire logic [7:0]         MOTOR_SUPPLY_VOLTAGE_IN,
  input wire logic               RIPPLE_PULSE_OUTPUT_OUT,
  input wire logic [1:0]         OUTPUT_ANALOG_CUTOFF_OUT,
  input wire logic [7:0]         MOTOR_VOLTAGE_OUT
);
  logic       unmapped;
  logic [8:0] hi_cnt_q;
  logic [8:0] hi_cnt_d;
  assign unmapped = !(PADDR_IN inside {OFS_TUNE, OFS_MOTOR, OFS_SPEED, OFS_COUNT});
  // consecutive high samples of the pulse, saturating
  always_comb begin
    hi_cnt_d = 9'h000;
    if (RIPPLE_PULSE_OUTPUT_OUT) begin
      hi_cnt_d = (hi_cnt_q == 9'h1FF) ? hi_cnt_q : hi_cnt_q + 9'h001;
    end
  end
  always_ff @(posedge REF_CLK_IN) begin
    hi_cnt_q <= RST_IN ? 9'h000 : hi_cnt_d;
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence setup_s;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence access_s;
    PSEL_IN && PENABLE_IN;
  endsequence
  ready_in_access_a: assert property (access_s |-> PREADY_OUT)
    else $error("no ready in access phase");
  err_unmapped_a: assert property (access_s ##0 unmapped |-> PSLVERR_OUT)
    else $error("unmapped access without error");
  err_quiet_a: assert property (!(PSEL_IN && PENABLE_IN && unmapped) |-> !PSLVERR_OUT)
    else $error("error raised without cause");
  read_zero_a: assert property (setup_s ##1 (access_s ##0 (!PWRITE_IN && unmapped))
    |-> PRDATA_OUT == 32'h00000000) else $error("unmapped read not zero");
  read_hold_a: assert property (!(PSEL_IN && !PENABLE_IN) |=> $stable(PRDATA_OUT))
    else $error("read data moved outside setup");
  speed_width_a: assert property (
    setup_s ##1 (access_s ##0 (!PWRITE_IN && PADDR_IN == OFS_SPEED))
    |-> PRDATA_OUT[31:8] == 24'h000000) else $error("speed wider than a byte");
  pulse_width_a: assert property (
    $fell(RIPPLE_PULSE_OUTPUT_OUT) |-> hi_cnt_q >= {1'b0, PULSE_LEN})
    else $error("ripple pulse too short");
  reset_quiet_a: assert property ($fell(RST_IN) |-> !RIPPLE_PULSE_OUTPUT_OUT
    && MOTOR_VOLTAGE_OUT == 8'h00 && OUTPUT_ANALOG_CUTOFF_OUT == 2'h0)
    else $error("outputs not cleared by reset");
endmodule
bind rct_ripple_tuning rct_ripple_tuning_properties chk_i (
  .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .MOTOR_CURRENT_IN(MOTOR_CURRENT_IN), .OUTPUT_DIFF_IN(OUTPUT_DIFF_IN),
  .PWM_DUTY_IN(PWM_DUTY_IN), .MOTOR_SUPPLY_VOLTAGE_IN(MOTOR_SUPPLY_VOLTAGE_IN),
  .RIPPLE_PULSE_OUTPUT_OUT(RIPPLE_PULSE_OUTPUT_OUT),
  .OUTPUT_ANALOG_CUTOFF_OUT(OUTPUT_ANALOG_CUTOFF_OUT),
  .MOTOR_VOLTAGE_OUT(MOTOR_VOLTAGE_OUT));

// ==== tb/tb.sv ====
// self-checking bench for the ripple counter tuning block
`timescale 1ns/1ps
module tb;
  import rct_pkg::*;
  logic               clk, rst, psel, penable, pwrite, pready, pslverr, pulse, err, ripple_on;
  logic        [7:0]  paddr, diff, duty, supply, volt, exp8;
  logic        [31:0] pwdata, prdata, rd, rs, v;
  logic signed [11:0] cur;
  logic        [1:0]  cutoff;
  logic        [15:0] pulses, minw;
  int                 bad_count, checks_done, phase, n;
  rct_ripple_tuning uut (
    .REF_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .MOTOR_CURRENT_IN(cur),
    .OUTPUT_DIFF_IN(diff), .PWM_DUTY_IN(duty), .MOTOR_SUPPLY_VOLTAGE_IN(supply),
    .RIPPLE_PULSE_OUTPUT_OUT(pulse), .OUTPUT_ANALOG_CUTOFF_OUT(cutoff),
    .MOTOR_VOLTAGE_OUT(volt));
  rct_host_model host (.clk_in(clk), .rst_in(rst), .pulse_in(pulse),
    .pulses_out(pulses), .min_width_out(minw));
  always #25 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] keep(input int w, input logic [31:0] d);
    return d & ((32'h1 << w) - 32'h1);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge clk);
    end
    if (k == 50) begin
      check("pready", 32'h1, 32'h0);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // square current ripple xored with the fixed low bits rs[3:0], period 80 cycles
  always @(posedge clk) begin
    if (ripple_on) begin
      phase <= (phase == 79) ? 0 : phase + 1;
      cur <= ((phase < 40) ? 12'sh300 : 12'shD00) ^ {8'h00, rs[3:0]};
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("Error watchdog expired");
    report_and_stop;
  end
  initial begin
    {clk, psel, penable, pwrite, ripple_on, paddr, pwdata, cur} = '0;
    {diff, duty, supply, bad_count, checks_done, phase} = '0;
    rst = 1'b1;
    rs = 32'h390F;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(0, OFS_TUNE, 0);
    check("gain", 32'h3, rd & 32'h3);
    check("quality", 32'h6, (rd >> F_QF) & 32'hF);
    check("mech", 32'h4, (rd >> F_MECH) & 32'h7);
    check("sense", 32'h0, (rd >> F_VSNS) & 32'h1);
    apb(0, OFS_MOTOR, 0);
    check("kmc", 32'hA3, rd & 32'hFF);
    check("kscale", 32'h3, (rd >> F_KSCL) & 32'h3);
    $display("done reset values");
    for (int i = 0; i < 16; i++) begin
      rs = xs(rs);
      v = (rs & ~32'h0000F03C) | (i << 2) | (i << 12);
      apb(1, OFS_TUNE, v);
      apb(1, OFS_MOTOR, rs >> 8);
      apb(0, OFS_TUNE, 0);
      check("tune", keep(TUNE_W, v), rd);
      apb(0, OFS_MOTOR, 0);
      check("motor", keep(MOTOR_W, rs >> 8), rd);
    end
    $display("done field readback");
    apb(1, OFS_SPEED, 32'hFFFFFFFF);
    apb(1, OFS_COUNT, 32'hFFFFFFFF);
    apb(1, 8'h10, 32'h00000000);
    check("write error", 32'h1, {31'h0, err});
    apb(0, 8'hFC, 0);
    check("read error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    apb(0, OFS_SPEED, 0);
    check("speed ro", 32'h0, rd);
    apb(0, OFS_COUNT, 0);
    check("count ro", 32'h0, rd);
    apb(0, OFS_TUNE, 0);
    check("tune kept", keep(TUNE_W, v), rd);
    $display("done access kinds");
    duty <= rs[7:0] | 8'h80;
    supply <= rs[15:8] | 8'h80;
    diff <= 8'h64;
    apb(1, OFS_TUNE, 32'h00000B1B);
    apb(1, OFS_MOTOR, 32'h00000301);
    ripple_on <= 1'b1;
    exp8 = 8'((16'(duty) * 16'(supply)) >> 8);
    n = 0;
    while (volt !== exp8 && n < 3000) begin
      n++;
      @(posedge clk);
    end
    check("digital volt", {24'h0, exp8}, {24'h0, volt});
    repeat (2000) @(posedge clk);
    apb(0, OFS_COUNT, 0);
    check("counted", 32'h1, {31'h0, rd[15:0] != 16'h0});
    check("pulses", 32'h1, {31'h0, pulses != 16'h0});
    check("pulse width", 32'h1, {31'h0, minw >= 16'(PULSE_LEN)});
    apb(0, OFS_SPEED, 0);
    check("speed", 32'h1, {31'h0, rd[7:0] != 8'h00});
    $display("done ripple traffic");
    apb(1, OFS_TUNE, 32'h0000091B);
    n = 0;
    while ((cutoff !== 2'h2 || volt > diff || volt + 8'd32 < diff) && n < 3000) begin
      n++;
      @(posedge clk);
    end
    check("cutoff", 32'h2, {30'h0, cutoff});
    check("analog volt", 32'h1, {31'h0, volt <= diff && volt + 8'd32 >= diff});
    $display("done analog sense");
    report_and_stop;
  end
endmodule
